// *** rtl/pmx_pkg.sv ***
// shared constants and size arithmetic for the priority message link
// assumes both ends are built with the same payload byte width
package pmx_pkg;

	// ****************************************************************
	// widths and reset values
	// ****************************************************************
	localparam int SIZE_W         = 3;  // width of the size code
	localparam int DATA_BYTES_DEF = 4;  // default payload bytes per beat
	localparam int MSG_MAX_BYTES  = 16; // longest message
	localparam int BEAT_W         = 5;  // beat counter width
	localparam int CNT_W          = 5;  // byte count width, 0..16
	localparam logic [SIZE_W-1:0] SIZE_RST  = 3'h0;
	localparam logic [BEAT_W-1:0] BEAT_ZERO = 5'h00;
	localparam logic [BEAT_W-1:0] BEAT_ONE  = 5'h01;

	// ****************************************************************
	// size code arithmetic
	// ****************************************************************
	// code k selects 2*(k+1) bytes
	function automatic logic [CNT_W-1:0] msg_len(
		input logic [SIZE_W-1:0] code);
		msg_len = CNT_W'({code, 1'b0}) + 5'h02;
	endfunction

	// beats on the payload bus, byte count over bus width rounded up
	function automatic logic [BEAT_W-1:0] msg_beats(
		input logic [SIZE_W-1:0] code,
		input int                bytes);
		int n;
		n = int'(msg_len(code));
		msg_beats = BEAT_W'((n + bytes - 1) / bytes);
	endfunction

	// bytes that are meaningful in the final beat
	function automatic logic [CNT_W-1:0] tail_bytes(
		input logic [SIZE_W-1:0] code,
		input int                bytes);
		int n;
		int b;
		n = int'(msg_len(code));
		b = int'(msg_beats(code, bytes));
		tail_bytes = CNT_W'(n - (b - 1) * bytes);
	endfunction

endpackage

// *** rtl/pmx_link_if.sv ***
// interface between the link core and the user application logic
// assumes one common clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
interface pmx_link_if
	import pmx_pkg::*;
#(
	parameter int BYTES = DATA_BYTES_DEF
) (
	input wire logic clk,
	input wire logic rst_n
);
	// message request and accept
	logic                 msgReq;
	logic [SIZE_W-1:0]    priority_msg_size_code;
	logic                 msgAck;
	// shared transmit payload bus
	logic [8*BYTES-1:0]   txData;
	logic                 txValid;
	logic                 txLast;
	logic                 txReady;
	// received message stream
	logic [8*BYTES-1:0]   rxMsgData;
	logic                 rxMsgValid;
	logic                 rxMsgLast;
	logic [BYTES-1:0]     rxMsgKeep;

	modport core (
		input  clk, rst_n, msgReq, priority_msg_size_code,
		input  txData, txValid, txLast,
		output msgAck, txReady,
		output rxMsgData, rxMsgValid, rxMsgLast, rxMsgKeep
	);

	modport user (
		input  clk, rst_n, msgAck, txReady,
		input  rxMsgData, rxMsgValid, rxMsgLast, rxMsgKeep,
		output msgReq, priority_msg_size_code,
		output txData, txValid, txLast
	);
endinterface
`default_nettype wire

// *** rtl/pmx_user_end.sv ***
// user application end: sends whole messages and a regular stream
// assumes the core end keeps the accept and ready timing
`timescale 1ns/1ps
`default_nettype none
module pmx_user_end
	import pmx_pkg::*;
#(
	parameter int BYTES = DATA_BYTES_DEF
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// link to the core
	pmx_link_if.user                      link,
	// message send port
	input  wire logic                     sendReq,
	input  wire logic [SIZE_W-1:0]        sendSize,
	input  wire logic [8*MSG_MAX_BYTES-1:0] sendMsg,
	output logic                          sendReady,
	// regular transmit stream
	input  wire logic [8*BYTES-1:0]       appTxData,
	input  wire logic                     appTxValid,
	input  wire logic                     appTxLast,
	output logic                          appTxReady,
	// received message stream
	output logic [8*BYTES-1:0]            appRxData,
	output logic                          appRxValid,
	output logic                          appRxLast,
	output logic [BYTES-1:0]              appRxKeep
);

	typedef enum logic [1:0] {U_IDLE, U_WAIT, U_REQ, U_SEND} pmx_ustate_e;

	pmx_ustate_e               state;
	logic [8*MSG_MAX_BYTES-1:0] msgBuf;
	logic [BEAT_W-1:0]         beatsLeft;
	logic                      takeMsg;
	logic                      nextValid;

	assign takeMsg   = sendReq && sendReady;
	assign nextValid = link.txValid ? !link.txReady : (appTxReady && appTxValid);

	// ****************************************************************
	// message sequencer
	// ****************************************************************
	// whole message is latched before asking, so every byte is at hand
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state                       <= U_IDLE;
			msgBuf                      <= '0;
			beatsLeft                   <= BEAT_ZERO;
			link.msgReq                 <= 1'b0;
			link.priority_msg_size_code <= SIZE_RST;
		end else begin
			unique case (state)
				U_IDLE: begin
					if (takeMsg) begin
						msgBuf                      <= sendMsg;
						link.priority_msg_size_code <= sendSize;
						state                       <= U_WAIT;
					end
				end
				U_WAIT: begin
					// let a pending regular beat drain first
					if (!link.txValid) begin
						link.msgReq <= 1'b1;
						state       <= U_REQ;
					end
				end
				U_REQ: begin
					// request held until the accept arrives
					if (link.msgAck) begin
						link.msgReq <= 1'b0;
						msgBuf      <= msgBuf >> (8 * BYTES);
						beatsLeft   <= msg_beats(link.priority_msg_size_code,
							BYTES) - BEAT_ONE;
						state       <= U_SEND;
					end
				end
				U_SEND: begin
					if (beatsLeft == BEAT_ZERO) begin
						state <= U_IDLE; // only now may a new one start
					end else begin
						msgBuf    <= msgBuf >> (8 * BYTES);
						beatsLeft <= beatsLeft - BEAT_ONE;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// shared payload bus
	// ****************************************************************
	// first message beat appears the cycle after accept
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link.txData  <= '0;
			link.txValid <= 1'b0;
			link.txLast  <= 1'b0;
		end else if (state == U_REQ && link.msgAck) begin
			link.txData <= msgBuf[8*BYTES-1:0];
		end else if (state == U_SEND && beatsLeft != BEAT_ZERO) begin
			link.txData <= msgBuf[8*BYTES-1:0];
		end else if (appTxReady && appTxValid) begin
			link.txData  <= appTxData;
			link.txValid <= 1'b1;
			link.txLast  <= appTxLast;
		end else if (link.txValid && link.txReady) begin
			link.txValid <= 1'b0;
		end
	end

	// one-deep holding, so regular data runs at half rate at best
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			appTxReady <= 1'b0;
		end else begin
			appTxReady <= state == U_IDLE && !takeMsg && !nextValid;
		end
	end

	// ready for a new message only when idle again
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sendReady <= 1'b0;
		end else begin
			sendReady <= (state == U_IDLE && !takeMsg) ||
				(state == U_SEND && beatsLeft == BEAT_ZERO);
		end
	end

	// ****************************************************************
	// received messages
	// ****************************************************************
	// registered copy of the message stream, no back-pressure exists
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			appRxData  <= '0;
			appRxValid <= 1'b0;
			appRxLast  <= 1'b0;
			appRxKeep  <= '0;
		end else begin
			appRxData  <= link.rxMsgData;
			appRxValid <= link.rxMsgValid;
			appRxLast  <= link.rxMsgLast;
			appRxKeep  <= link.rxMsgKeep;
		end
	end

endmodule
`default_nettype wire

// *** rtl/pmx_core_end.sv ***
// link core end: accepts priority messages and regular data from the
// user, hands them to the lane, and delivers received messages
// assumes lane logic on the same clock; lane has no back-pressure on
// messages, and received messages arrive already framed
//
// Functional notes
// - user holds request until accept
// - message bytes start cycle after accept
// - ready low while bus carries message
// - new request only after previous completes
// - start only with whole message available
// - accepted message runs without interruption
// - beats equal bytes over width, rounded up
// - 4 bytes on 4-byte bus: two-cycle gap
// - 4 bytes on 2-byte bus: three-cycle gap
// - received message on own stream port
// - final beat byte mask shows valid bytes
// - single-beat message: valid, last, full mask
// - two-beat message, full mask on second
// - size code k means 2*(k+1) bytes
// - bytes past message length are discarded
`timescale 1ns/1ps
`default_nettype none
module pmx_core_end
	import pmx_pkg::*;
#(
	parameter int BYTES = DATA_BYTES_DEF
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// link to the user application
	pmx_link_if.core                   link,
	// regular data toward the lane
	input  wire logic                  laneReady,
	output logic [8*BYTES-1:0]         laneData,
	output logic                       laneValid,
	output logic                       laneLast,
	// message header toward the lane
	output logic                       laneHdrSend,
	output logic [SIZE_W-1:0]          laneHdrSize,
	// message data toward the lane
	output logic [8*BYTES-1:0]         laneMsgData,
	output logic                       laneMsgValid,
	output logic                       laneMsgLast,
	output logic [BYTES-1:0]           laneMsgKeep,
	// received message from the lane
	input  wire logic [8*BYTES-1:0]    laneRxData,
	input  wire logic                  laneRxValid,
	input  wire logic                  laneRxLast,
	input  wire logic [CNT_W-1:0]      laneRxBytes
);

	// ****************************************************************
	// types and helpers
	// ****************************************************************
	typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_DATA} pmx_txstate_e;

	// low n bytes marked valid
	function automatic logic [BYTES-1:0] keep_of(
		input logic [CNT_W-1:0] n);
		keep_of = '0;
		for (int i = 0; i < BYTES; i++) begin
			keep_of[i] = (CNT_W'(i) < n);
		end
	endfunction

	// zero every byte whose keep bit is clear
	function automatic logic [8*BYTES-1:0] mask_data(
		input logic [8*BYTES-1:0] d,
		input logic [BYTES-1:0]   k);
		mask_data = '0;
		for (int i = 0; i < BYTES; i++) begin
			mask_data[8*i +: 8] = k[i] ? d[8*i +: 8] : 8'h00;
		end
	endfunction

	pmx_txstate_e      txState;
	logic [SIZE_W-1:0] sizeCap;
	logic [BEAT_W-1:0] beatsLeft;
	logic              lastBeat;
	logic [BYTES-1:0]  beatKeep;

	assign lastBeat = (beatsLeft == BEAT_ONE);
	// final beat keeps only the bytes inside the message length
	assign beatKeep = lastBeat ? keep_of(tail_bytes(sizeCap, BYTES))
		: '1;

	// ****************************************************************
	// message sequencer
	// ****************************************************************
	// accept cycle carries the header, then one cycle per data beat;
	// the sequencer never reads the lane ready input, so nothing
	// can pause a message midway
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			txState     <= TX_IDLE;
			link.msgAck <= 1'b0;
			beatsLeft   <= BEAT_ZERO;
		end else begin
			unique case (txState)
				TX_IDLE: begin
					// a request left high after completion is a new one;
					// back to back requests still get a full sequence
					if (link.msgReq) begin
						link.msgAck <= 1'b1;
						txState     <= TX_HDR;
					end
				end
				TX_HDR: begin
					link.msgAck <= 1'b0;
					beatsLeft   <= msg_beats(link.priority_msg_size_code,
						BYTES);
					txState     <= TX_DATA;
				end
				TX_DATA: begin
					beatsLeft <= beatsLeft - BEAT_ONE;
					if (lastBeat) begin
						txState <= TX_IDLE;
					end
				end
			endcase
		end
	end

	// size taken once, in the accept cycle; later changes are ignored
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sizeCap <= SIZE_RST;
		end else if (txState == TX_HDR) begin
			sizeCap <= link.priority_msg_size_code;
		end
	end

	// ****************************************************************
	// payload ready
	// ****************************************************************
	// low from the accept cycle through the final message beat, so the
	// gap is one header cycle plus the data beats
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link.txReady <= 1'b0;
		end else begin
			unique case (txState)
				TX_IDLE: link.txReady <= laneReady && !link.msgReq;
				TX_HDR:  link.txReady <= 1'b0;
				TX_DATA: link.txReady <= lastBeat && laneReady;
			endcase
		end
	end

	// ****************************************************************
	// lane side of the transmit path
	// ****************************************************************
	// header strobe goes out with the size seen in the accept cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			laneHdrSend <= 1'b0;
			laneHdrSize <= SIZE_RST;
		end else begin
			laneHdrSend <= (txState == TX_HDR);
			if (txState == TX_HDR) begin
				laneHdrSize <= link.priority_msg_size_code;
			end
		end
	end

	// every data cycle is a message beat; valid from the user is not
	// needed, the beat count alone frames the message
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			laneMsgData  <= '0;
			laneMsgValid <= 1'b0;
			laneMsgLast  <= 1'b0;
			laneMsgKeep  <= '0;
		end else begin
			laneMsgValid <= (txState == TX_DATA);
			laneMsgLast  <= (txState == TX_DATA) && lastBeat;
			laneMsgKeep  <= beatKeep;
			laneMsgData  <= mask_data(link.txData, beatKeep);
		end
	end

	// regular data passes only on a real handshake, never in a gap
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			laneData  <= '0;
			laneValid <= 1'b0;
			laneLast  <= 1'b0;
		end else begin
			laneValid <= link.txValid && link.txReady;
			laneLast  <= link.txLast;
			laneData  <= link.txData;
		end
	end

	// ****************************************************************
	// receive path
	// ****************************************************************
	// messages have their own stream, apart from regular data; the mask
	// is all ones on middle beats and counts valid bytes on the last,
	// so 4 of 4 bytes reads as 4'hf
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link.rxMsgData  <= '0;
			link.rxMsgValid <= 1'b0;
			link.rxMsgLast  <= 1'b0;
			link.rxMsgKeep  <= '0;
		end else begin
			link.rxMsgValid <= laneRxValid;
			link.rxMsgLast  <= laneRxValid && laneRxLast;
			link.rxMsgData  <= laneRxData;
			link.rxMsgKeep  <= laneRxLast ? keep_of(laneRxBytes)
				: '1;
		end
	end

endmodule
`default_nettype wire

// *** sim/pmx_link_sva.sv ***
// assertions on the link between the user end and the core end
// assumes the bench instantiates it beside the link interface
`timescale 1ns/1ps
`default_nettype none
module pmx_link_sva
	import pmx_pkg::*;
#(
	parameter int BYTES = DATA_BYTES_DEF
) (
	// clock and reset
	input wire logic              clk,
	input wire logic              rst_n,
	// message request side
	input wire logic              msgReq,
	input wire logic [SIZE_W-1:0] priority_msg_size_code,
	input wire logic              msgAck,
	input wire logic              txValid,
	input wire logic              txReady,
	// received message stream
	input wire logic              rxMsgValid,
	input wire logic              rxMsgLast,
	input wire logic [BYTES-1:0]  rxMsgKeep
);
	// ******************************************
	// beats still owed by the accepted message
	// ******************************************
	logic [BEAT_W-1:0] left;

	// size sampled in the accept cycle only, later changes ignored
	always_ff @(posedge clk) begin
		if (!rst_n)
			left <= BEAT_ZERO;
		else if (msgAck)
			left <= BEAT_W'((2 * priority_msg_size_code + 1 + BYTES)
				/ BYTES);
		else if (left != BEAT_ZERO)
			left <= left - BEAT_ONE;
	end

	// ******************************************
	// properties
	// ******************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_ack_after_req: assert property ($rose(msgReq) |=> msgAck)
		else $error("accept missing after request");
	a_ack_has_req: assert property (msgAck |-> $past(msgReq))
		else $error("accept without request");
	a_ack_one_pulse: assert property (msgAck |=> !msgAck)
		else $error("accept held too long");
	a_gap_at_ack: assert property (msgAck |-> !txReady)
		else $error("ready high in accept cycle");
	a_gap_per_beat: assert property (
		left != BEAT_ZERO |-> !txReady && !msgAck)
		else $error("ready high while message beats owed");
	a_rx_full_keep: assert property (rxMsgValid && !rxMsgLast |-> &rxMsgKeep)
		else $error("partial mask before last beat");
	a_rx_tail_keep: assert property (
		rxMsgValid && rxMsgLast |-> rxMsgKeep[0]
		&& ((rxMsgKeep & (rxMsgKeep + 1'b1)) == '0))
		else $error("last beat mask not a low run");
	a_rx_last_valid: assert property (rxMsgLast |-> rxMsgValid)
		else $error("last without valid");

	// main scenarios reached
	c_long_msg: cover property (msgAck && priority_msg_size_code == 3'h7);
	c_rx_single: cover property (rxMsgValid && rxMsgLast && &rxMsgKeep);
	c_regular: cover property (txValid && txReady);
	c_short_msg: cover property (msgAck && priority_msg_size_code == 3'h0);
	c_rx_multi: cover property (rxMsgValid && !rxMsgLast);
endmodule
`default_nettype wire

// *** sim/pmx_bench.sv ***
// self-checking bench: user end and core end joined by the link
// assumes 4-byte payload beats and a 50 ns clock
`timescale 1ns/1ps
`default_nettype none
module pmx_bench
	import pmx_pkg::*;
;
	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              sendReq = 1'b0;
	logic [SIZE_W-1:0] sendSize = 3'h0;
	logic [127:0]      sendMsg = '0;
	logic [31:0]       appTxData = 32'h0;
	logic              appTxValid = 1'b0;
	logic              appTxLast = 1'b0;
	logic              laneReady = 1'b1;
	logic [31:0]       laneRxData = 32'h0;
	logic              laneRxValid = 1'b0;
	logic              laneRxLast = 1'b0;
	logic [CNT_W-1:0]  laneRxBytes = 5'h00;
	logic              sendReady, appTxReady, appRxValid, appRxLast;
	logic              laneValid, laneLast, laneHdrSend, laneMsgValid, laneMsgLast;
	logic [31:0]       appRxData, laneData, laneMsgData;
	logic [3:0]        appRxKeep, laneMsgKeep;
	logic [SIZE_W-1:0] laneHdrSize;
	logic [31:0]       seed = 32'h9e479383;
	logic              jitter = 1'b0;
	logic [36:0]       msgQ[$], rxQ[$];
	logic [32:0]       regQ[$], regExp[$];
	logic [2:0]        hdrQ[$];
	int                low = 0;
	int                cycles = 0;
	int                n_errors = 0;
	int                n_tests = 0;

	pmx_link_if #(.BYTES(4)) link (.clk, .rst_n);
	pmx_user_end #(.BYTES(4)) i_pmx_user_end (.clk, .rst_n, .link, .sendReq,
		.sendSize, .sendMsg, .sendReady, .appTxData, .appTxValid, .appTxLast,
		.appTxReady, .appRxData, .appRxValid, .appRxLast, .appRxKeep);
	pmx_core_end #(.BYTES(4)) i_pmx_core_end (.clk, .rst_n, .link, .laneReady,
		.laneData, .laneValid, .laneLast, .laneHdrSend, .laneHdrSize,
		.laneMsgData, .laneMsgValid, .laneMsgLast, .laneMsgKeep, .laneRxData,
		.laneRxValid, .laneRxLast, .laneRxBytes);
	pmx_link_sva #(.BYTES(4)) i_pmx_link_sva (.clk, .rst_n,
		.msgReq(link.msgReq), .msgAck(link.msgAck),
		.priority_msg_size_code(link.priority_msg_size_code),
		.txValid(link.txValid), .txReady(link.txReady),
		.rxMsgValid(link.rxMsgValid), .rxMsgLast(link.rxMsgLast),
		.rxMsgKeep(link.rxMsgKeep));

	// ******************************************
	// clock, monitors, watchdog
	// ******************************************
	initial begin
		forever #25 clk = ~clk;
	end

	// record lane and user outputs; count cycles with ready low
	always @(posedge clk) begin
		if (!link.txReady)
			low++;
		if (laneMsgValid)
			msgQ.push_back({laneMsgLast, laneMsgKeep, laneMsgData});
		if (laneHdrSend)
			hdrQ.push_back(laneHdrSize);
		if (laneValid)
			regQ.push_back({laneLast, laneData});
		if (appRxValid)
			rxQ.push_back({appRxLast, appRxKeep, appRxData});
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			wrap_up();
		end
	end

	// lane stalls at random only in the regular data test
	always @(posedge clk) begin
		#1 laneReady = !jitter || rnd() > 32'h60000000;
	end

	// ******************************************
	// helpers
	// ******************************************
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// one beat: bytes past the length are zero, mask marks real bytes
	function automatic logic [36:0] exp_beat(logic [127:0] m, int len, int b);
		logic [36:0] e;
		e = '0;
		for (int i = 0; i < 4; i++) begin
			if (4 * b + i < len) begin
				e[8*i +: 8] = m[8*(4*b+i) +: 8];
				e[32+i] = 1'b1;
			end
		end
		e[36] = (4 * b + 4 >= len);
		return e;
	endfunction

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic send_msg(input logic [2:0] code);
		logic [127:0] m;
		logic [36:0]  e;
		int nb;
		m = {rnd(), rnd(), rnd(), rnd()};
		nb = (2 * code + 5) / 4;
		while (sendReady !== 1'b1) @(posedge clk) #1;
		sendSize = code;
		sendMsg = m; // whole message ready before the request
		sendReq = 1'b1;
		@(posedge clk) #1;
		sendReq = 1'b0;
		sendSize = ~code;
		low = 0;
		while (!(sendReady === 1'b1 && msgQ.size() >= nb)) @(posedge clk) #1;
		if (!jitter) check(low, nb + 1);
		check(hdrQ.pop_front(), code);
		// beats must come in byte order, each with the expected data, mask and last flag
		for (int b = 0; b < nb; b++) begin
			e = exp_beat(m, 2 * code + 2, b);
			check(msgQ.pop_front(), e);
		end
	endtask

	task automatic recv_msg(input logic [2:0] code);
		logic [127:0] m;
		logic [36:0] e[$];
		int len;
		m = {rnd(), rnd(), rnd(), rnd()};
		len = 2 * code + 2;
		for (int b = 0; 4 * b < len; b++) begin
			e.push_back(exp_beat(m, len, b));
			laneRxValid = 1'b1;
			laneRxData = e[b][31:0];
			laneRxLast = e[b][36];
			laneRxBytes = CNT_W'(len - 4 * b > 4 ? 4 : len - 4 * b);
			@(posedge clk) #1;
		end
		laneRxValid = 1'b0;
		laneRxLast = 1'b0;
		laneRxData = ~laneRxData; // idle data is junk on purpose
		repeat (3) @(posedge clk) #1;
		check(rxQ.size(), e.size());
		foreach (e[i]) check(rxQ.pop_front(), e[i]);
	endtask

	task automatic send_reg(input logic [31:0] d, input logic l);
		appTxData = d;
		appTxLast = l;
		appTxValid = 1'b1;
		while (appTxReady !== 1'b1) @(posedge clk) #1;
		@(posedge clk) #1;
		regExp.push_back({l, d});
	endtask

	task automatic wrap_up();
		$display("counts: %0d compares, %0d mismatches", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ******************************************
	// main sequence
	// ******************************************
	initial begin
		repeat (16) @(posedge clk);
		#1 rst_n = 1'b1;
		// every size code, then random ones
		for (int c = 0; c < 12; c++) send_msg(c < 8 ? 3'(c) : 3'(rnd()));
		$display("done: transmit messages");
		for (int c = 0; c < 12; c++) recv_msg(c < 8 ? 3'(c) : 3'(rnd()));
		$display("done: receive messages");
		// regular stream with a message cut into it, lane stalling
		jitter = 1'b1;
		fork
			begin
				for (int i = 0; i < 24; i++) send_reg(rnd(), i % 6 == 5);
				// drop valid at once, or the last beat could go twice
				appTxValid = 1'b0;
			end
			begin
				repeat (9) @(posedge clk);
				#1 send_msg(3'h7);
			end
		join
		jitter = 1'b0;
		repeat (6) @(posedge clk) #1;
		check(regQ.size(), regExp.size());
		foreach (regExp[i]) check(regQ.pop_front(), regExp[i]);
		$display("done: regular data around a message");
		wrap_up();
	end
endmodule
`default_nettype wire
